// file: hdl/acx_defs.svh
/*
  acx_defs.svh: widths, field positions, reset values and timing counts
  for the asynchronous counter with crystal oscillator.
  assumes: included by bare name from package and design files.
*/
`ifndef ACX_DEFS_SVH
`define ACX_DEFS_SVH

// ---------------------------------------------------------------
// counter geometry
// ---------------------------------------------------------------
`define ACX_COUNT_W 16
`define ACX_BYTE_W 8
`define ACX_COUNT_RST 16'h0000
`define ACX_COUNT_MAX 16'hffff

// ---------------------------------------------------------------
// counter_control_register bit positions (bits arrive as ports)
// ---------------------------------------------------------------
`define ACX_CTL_SYNC_BYPASS_BIT 2
`define ACX_CTL_OSC_ENABLE_BIT 3

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ACX_CORE_CLK_HZ 25000000
`define ACX_PHASE_DIV 4
`define ACX_XTAL_MAX_HZ 200000
`define ACX_XTAL_NOM_HZ 32000
// core cycles per half period of the fastest crystal, rounded down
`define ACX_XTAL_HALF_CYC (`ACX_CORE_CLK_HZ / (2 * `ACX_XTAL_MAX_HZ))
`define ACX_PRESCALE_MAX_LOG2 3

`endif

// file: hdl/acx_pkg.sv
/*
  acx_pkg: types shared by the asynchronous counter block.
  assumes: acx_defs.svh is on the include path.
*/
`include "acx_defs.svh"

package acx_pkg;

	// ---------------------------------------------------------------
	// control bits from the processor side
	// ---------------------------------------------------------------
	typedef struct packed {
		logic run;
		logic src_ext;
		logic sync_bypass_bit;
		logic crystal_osc_enable_bit;
		logic [1:0] prescale_sel;
	} acx_ctl_t;

	// ---------------------------------------------------------------
	// byte access to the count
	// ---------------------------------------------------------------
	typedef struct packed {
		logic rd;
		logic wr;
		logic sel_high;
		logic [`ACX_BYTE_W-1:0] wdata;
	} acx_acc_t;

endpackage : acx_pkg

// file: hdl/acx_sync.sv
/*
  acx_sync: two flip-flop synchroniser for levels arriving from pins.
  assumes: one clock; reset is the already released internal copy.
*/
`timescale 1ns/100ps

module acx_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// ---------------------------------------------------------------
	// first stage feeds only the second stage
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : acx_sync

// file: hdl/acx_counter.sv
/*
  acx_counter: 16-bit counter with prescaler, synchronised or asynchronous
  external counting, and a low-power crystal oscillator amplifier model.
  assumes: processor-side ports are on core_clk; the crystal pin is not.
*/
`timescale 1ns/100ps
`include "acx_defs.svh"

// Summary of operation
// - with the bypass bit set the external clock is counted without waiting for a phase slot.
// - in asynchronous mode the count runs through sleep and its overflow wakes the processor.
// - in asynchronous mode the count is not offered as a capture or compare time base.
// - a read of either count byte returns a whole, stable byte.
// - the crystal amplifier runs only while the oscillator enable bit is set.
// - the oscillator is a low-power type for crystals up to 200 kHz, chiefly 32 kHz.
// - an enabled oscillator keeps running through sleep.
// - the count is 16 bits and counts the phase clock, an external clock or the crystal.
// - a prescaler divides the chosen source by 1, 2, 4 or 8.
module acx_counter
	import acx_pkg::*;
#(
	parameter int COUNT_W = `ACX_COUNT_W,
	parameter int CORE_CLK_HZ = `ACX_CORE_CLK_HZ
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire acx_ctl_t ctl,
	input wire acx_acc_t acc,
	input wire logic sleep,
	input wire logic ovf_clear,
	input wire logic crystal_input_pin,
	output logic crystal_amp_output_pin_o,
	output logic crystal_amp_output_pin_oe_n,
	output logic [`ACX_BYTE_W-1:0] rdata_q,
	output logic rvalid_q,
	output logic [COUNT_W-1:0] count_high_low_q,
	output logic timebase_ok_q,
	output logic overflow_flag_q,
	output logic wake_q
);

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	initial
	begin
		if (COUNT_W != 2 * `ACX_BYTE_W)
			$error("count must be exactly two bytes wide");
		if (CORE_CLK_HZ / (2 * `ACX_XTAL_MAX_HZ) < 2)
			$error("core clock too slow to sample the crystal");
	end

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic [1:0] rst_q;
	logic rst_n;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	// ---------------------------------------------------------------
	// pin sampling and phase divider
	// ---------------------------------------------------------------
	logic xin_s;
	logic xin_prev_q, xin_prev_d;
	logic [1:0] div_q, div_d;
	logic phase_en, ext_rise;

	acx_sync #(.WIDTH(1)) u_xin_sync (
		.clk(core_clk),
		.rst_n(rst_n),
		.d(crystal_input_pin),
		.q(xin_s)
	);

	always_comb
	begin
		div_d = div_q + 2'h1;
		xin_prev_d = xin_s;
		phase_en = (div_q == 2'(`ACX_PHASE_DIV - 1));
		ext_rise = xin_s & ~xin_prev_q;
	end

	// ---------------------------------------------------------------
	// prescaler and increment selection
	// ---------------------------------------------------------------
	logic async_mode;
	logic pre_evt, pre_tick, inc;
	logic [2:0] pre_q, pre_d, pre_mask;
	logic pend_q, pend_d;

	always_comb
	begin
		// the phase clock stops in sleep; only the asynchronous path ignores it
		async_mode = ctl.src_ext & ctl.sync_bypass_bit;
		pre_evt = ctl.run & (ctl.src_ext ? ext_rise : (phase_en & ~sleep));
		pre_mask = 3'((4'h1 << ctl.prescale_sel) - 4'h1);
		pre_tick = pre_evt & ((pre_q & pre_mask) == pre_mask);
		pre_d = pre_q;
		if (!ctl.run)
			pre_d = 3'h0;
		else if (pre_tick)
			pre_d = 3'h0;
		else if (pre_evt)
			pre_d = pre_q + 3'h1;
		pend_d = pend_q;
		inc = 1'b0;
		if (async_mode)
		begin
			pend_d = 1'b0;
			inc = pre_tick;
		end
		else if (ctl.src_ext)
		begin
			// a synchronised edge waits for an awake phase slot
			inc = pend_q & phase_en & ~sleep;
			pend_d = pre_tick | (pend_q & ~inc);
		end
		else
		begin
			pend_d = 1'b0;
			inc = pre_tick;
		end
	end

	// ---------------------------------------------------------------
	// count, overflow and byte access
	// ---------------------------------------------------------------
	logic [COUNT_W-1:0] cnt_d;
	logic ovf_set, ovf_d, wake_d, tb_d, rvalid_d;
	logic [`ACX_BYTE_W-1:0] rdata_d;

	always_comb
	begin
		cnt_d = count_high_low_q;
		ovf_set = 1'b0;
		if (acc.wr)
		begin
			// a write beats a clashing step; software should stop first
			if (acc.sel_high)
				cnt_d[COUNT_W-1:`ACX_BYTE_W] = acc.wdata;
			else
				cnt_d[`ACX_BYTE_W-1:0] = acc.wdata;
		end
		else if (inc)
		begin
			cnt_d = count_high_low_q + 16'h0001;
			ovf_set = (count_high_low_q == `ACX_COUNT_MAX);
		end
		ovf_d = ovf_set | (overflow_flag_q & ~ovf_clear);
		wake_d = ovf_set & sleep;
		tb_d = ~async_mode;
		rvalid_d = acc.rd;
		rdata_d = rdata_q;
		if (acc.rd)
			rdata_d = acc.sel_high ? count_high_low_q[COUNT_W-1:`ACX_BYTE_W]
				: count_high_low_q[`ACX_BYTE_W-1:0];
	end

	// ---------------------------------------------------------------
	// crystal amplifier
	// ---------------------------------------------------------------
	logic amp_d, amp_oe_n_d;

	always_comb
	begin
		// sleep is deliberately not a term here
		amp_oe_n_d = ~ctl.crystal_osc_enable_bit;
		amp_d = ctl.crystal_osc_enable_bit & ~xin_s;
	end

	// ---------------------------------------------------------------
	// state registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_q <= 2'h0;
			xin_prev_q <= 1'b0;
			pre_q <= 3'h0;
			pend_q <= 1'b0;
			count_high_low_q <= `ACX_COUNT_RST;
			overflow_flag_q <= 1'b0;
			wake_q <= 1'b0;
			timebase_ok_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 8'h00;
			crystal_amp_output_pin_o <= 1'b0;
			crystal_amp_output_pin_oe_n <= 1'b1;
		end
		else
		begin
			div_q <= div_d;
			xin_prev_q <= xin_prev_d;
			pre_q <= pre_d;
			pend_q <= pend_d;
			count_high_low_q <= cnt_d;
			overflow_flag_q <= ovf_d;
			wake_q <= wake_d;
			timebase_ok_q <= tb_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			crystal_amp_output_pin_o <= amp_d;
			crystal_amp_output_pin_oe_n <= amp_oe_n_d;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	// events since the prescaler last restarted, counted apart from its own register
	logic [3:0] evt_cnt_q;
	logic [1:0] evt_sel_q;
	logic evt_ok_q;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			evt_cnt_q <= 4'h0;
			evt_sel_q <= 2'h0;
			evt_ok_q <= 1'b0;
		end
		else
		begin
			evt_sel_q <= ctl.prescale_sel;
			// a ratio change while running leaves the count meaningless until a restart
			evt_ok_q <= !ctl.run || pre_tick || (evt_ok_q && ctl.prescale_sel == evt_sel_q);
			if (!ctl.run || pre_tick)
				evt_cnt_q <= 4'h0;
			else if (pre_evt)
				evt_cnt_q <= evt_cnt_q + 4'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_async_no_phase: assert property (
		(async_mode && pre_tick && !phase_en && !acc.wr)
		|=> count_high_low_q == $past(count_high_low_q) + 16'h0001)
		else $error("asynchronous step waited for a phase slot");
	a_async_sleep_count: assert property (
		(async_mode && sleep && pre_tick && !acc.wr)
		|=> count_high_low_q == $past(count_high_low_q) + 16'h0001)
		else $error("asynchronous count stalled in sleep");
	a_sync_sleep_hold: assert property (
		(!async_mode && sleep && !acc.wr)
		|=> count_high_low_q == $past(count_high_low_q))
		else $error("synchronised count moved in sleep");
	a_overflow_wake: assert property (
		(inc && !acc.wr && sleep && count_high_low_q == 16'hffff)
		|=> wake_q && overflow_flag_q ##1 !wake_q)
		else $error("overflow in sleep gave no single wake pulse");
	a_timebase_async: assert property (
		async_mode |=> !timebase_ok_q)
		else $error("time base offered in asynchronous mode");
	a_read_low_byte: assert property (
		(acc.rd && !acc.sel_high)
		|=> rvalid_q && rdata_q == $past(count_high_low_q[7:0]))
		else $error("low byte read returned a wrong value");
	a_osc_gate: assert property (
		!ctl.crystal_osc_enable_bit [*2]
		|-> crystal_amp_output_pin_oe_n && !crystal_amp_output_pin_o)
		else $error("crystal amplifier active while disabled");
	a_osc_sleep: assert property (
		(ctl.crystal_osc_enable_bit && sleep) |=> !crystal_amp_output_pin_oe_n)
		else $error("oscillator stopped in sleep");
	a_prescale_div8: assert property (
		(evt_ok_q && pre_tick && ctl.prescale_sel == evt_sel_q)
		|-> evt_cnt_q == 4'((4'h1 << ctl.prescale_sel) - 4'h1))
		else $error("prescaler ratio differs from the selection");
	a_flag_sticky: assert property (
		(overflow_flag_q && !ovf_clear) |=> overflow_flag_q)
		else $error("overflow flag dropped without a clear");

	c_async_overflow: cover property (async_mode && ovf_set);
	c_sync_pending: cover property (pend_q && sleep ##1 pend_q);
	c_write_clash: cover property (acc.wr && inc);
	c_prescale_tick: cover property (ctl.prescale_sel == 2'h3 && pre_tick);

endmodule : acx_counter

// file: verification/acx_xtal_model.sv
/*
  acx_xtal_model: crystal or external clock on the crystal input pin.
  assumes: half period in ns from the bench; stands still when stopped.
*/
`timescale 1ns/100ps

module acx_xtal_model (
	input wire logic osc_run,
	input wire logic amp_oe_n,
	input wire logic [15:0] half_ns,
	output logic crystal_input_pin
);
	initial crystal_input_pin = 1'b0;

	// no oscillation unless the amplifier drives the crystal
	always
	begin
		wait (osc_run && !amp_oe_n);
		#(half_ns) crystal_input_pin = ~crystal_input_pin;
	end
endmodule : acx_xtal_model

// file: verification/testbench.sv
/*
  testbench: counts crystal edges in asynchronous mode at every prescale.
  assumes: acx_pkg compiled first; crystal model drives the pin.
*/
`timescale 1ns/100ps

module testbench;
	import acx_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	acx_ctl_t ctl = '0;
	acx_acc_t acc = '0;
	logic sleep = 1'b0;
	logic ovf_clear = 1'b0;
	logic osc_run = 1'b0;
	logic [15:0] half_ns = 16'h09c4;
	logic pin, amp_o, amp_oe_n, rvalid_q, ovf_q, wake_q, tb_ok;
	logic [7:0] rdata_q;
	logic [15:0] count_q;
	int fail_count = 0;
	int n_checks = 0;
	int edges = 0;
	int wakes = 0;
	int cycles = 0;
	bit counting = 0;

	always #20 core_clk = ~core_clk;

	acx_counter DUT (.core_clk(core_clk), .reset_n(reset_n), .ctl(ctl), .acc(acc),
		.sleep(sleep), .ovf_clear(ovf_clear), .crystal_input_pin(pin),
		.crystal_amp_output_pin_o(amp_o), .crystal_amp_output_pin_oe_n(amp_oe_n),
		.rdata_q(rdata_q), .rvalid_q(rvalid_q), .count_high_low_q(count_q),
		.timebase_ok_q(tb_ok), .overflow_flag_q(ovf_q), .wake_q(wake_q));

	acx_xtal_model xtal (.osc_run(osc_run), .amp_oe_n(amp_oe_n), .half_ns(half_ns),
		.crystal_input_pin(pin));

	// ---------------------------------------------------------------
	// monitors and run limit
	// ---------------------------------------------------------------
	always @(posedge pin) if (counting) edges++;

	always @(posedge core_clk)
	begin
		if (reset_n && wake_q === 1'b1) wakes++;
		cycles++;
		if (cycles > 80000)
		begin
			fail_count++;
			give_verdict();
		end
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic cyc(input int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr_byte(input logic hi, input logic [7:0] d);
		acc = '{rd: 1'b0, wr: 1'b1, sel_high: hi, wdata: d};
		cyc();
		acc.wr = 1'b0;
		cyc();
	endtask : wr_byte

	// count loaded with the counter stopped, high byte first
	task automatic load(input logic [15:0] v);
		wr_byte(1'b1, v[15:8]);
		wr_byte(1'b0, v[7:0]);
	endtask : load

	// crystal runs for n core clock cycles, then settles long enough for its last edge to land
	task automatic run_xtal(input int n);
		edges = 0;
		counting = 1;
		cyc(3);
		osc_run = 1'b1;
		cyc(n);
		osc_run = 1'b0;
		cyc(120);
		counting = 0;
	endtask : run_xtal

	// strobe is left high; the caller drops it after the last read
	task automatic rd_byte(input logic hi, output logic [7:0] d);
		acc.rd = 1'b1;
		acc.sel_high = hi;
		cyc();
		chk({15'h0000, rvalid_q}, 16'h0001);
		d = rdata_q;
	endtask : rd_byte

	// high, low, high again; a moved high byte means the low byte rolled
	task automatic rd16(output logic [15:0] v);
		logic [7:0] h1, lo, h2;
		rd_byte(1'b1, h1);
		rd_byte(1'b0, lo);
		rd_byte(1'b1, h2);
		if (h1 !== h2)
		begin
			rd_byte(1'b1, h1);
			rd_byte(1'b0, lo);
		end
		acc.rd = 1'b0;
		v = {h1, lo};
	endtask : rd16

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		logic [15:0] start, exp, got;
		int ticks, roll;
		void'($urandom(32'h044e));
		cyc(10);
		reset_n = 1'b1;
		cyc(3);
		chk(count_q, 16'h0000);
		chk({14'h0000, tb_ok, amp_oe_n}, 16'h0003);
		chk({14'h0000, ovf_q, wake_q}, 16'h0000);
		$display("test reset done");
		ctl.crystal_osc_enable_bit = 1'b1;
		ctl.src_ext = 1'b1;
		ctl.sync_bypass_bit = 1'b1;
		sleep = 1'b1;
		cyc(3);
		chk({15'h0000, amp_oe_n}, 16'h0000);
		chk({15'h0000, tb_ok}, 16'h0000);
		// pass 4 leaves the counter stopped while the crystal runs
		for (int i = 0; i < 5; i++)
		begin
			ctl.run = 1'b0;
			ctl.prescale_sel = i[1:0];
			start = 16'hffff - 16'($urandom_range(20));
			wr_byte(1'b1, start[15:8]);
			wr_byte(1'b0, start[7:0]);
			ovf_clear = 1'b1;
			cyc();
			ovf_clear = 1'b0;
			cyc();
			chk({15'h0000, ovf_q}, 16'h0000);
			ctl.run = 1'(i < 4);
			half_ns = 16'd2500 + 16'($urandom_range(1000));
			wakes = 0;
			run_xtal($urandom_range(3000, 1000));
			ticks = (i < 4) ? (edges >> i) : 0;
			roll = (int'(start) + ticks > 65535);
			exp = start + 16'(ticks);
			chk(count_q, exp);
			rd16(got);
			chk(got, exp);
			chk({15'h0000, ovf_q}, 16'(roll));
			chk(16'(wakes), 16'(roll));
			chk({15'h0000, amp_o}, {15'h0000, ~pin});
			$display("test prescale pass %0d done", i);
		end
		// internal phase clock: stalls in sleep, one event per four cycles awake
		ctl.src_ext = 1'b0;
		ctl.sync_bypass_bit = 1'b0;
		ctl.run = 1'b0;
		ctl.prescale_sel = 2'($urandom_range(3));
		load(16'h0000);
		ticks = $urandom_range(50, 10);
		ctl.run = 1'b1;
		cyc(4 * ticks);
		ctl.run = 1'b0;
		cyc();
		chk(count_q, 16'h0000);
		sleep = 1'b0;
		ctl.run = 1'b1;
		cyc(4 * ticks);
		ctl.run = 1'b0;
		chk(count_q, 16'(ticks >> ctl.prescale_sel));
		// reads while the count runs across a high byte carry
		ctl.prescale_sel = 2'h0;
		cyc();
		load(16'h00fa);
		ctl.run = 1'b1;
		for (int j = 0; j < 8; j++)
		begin
			start = count_q;
			rd16(got);
			chk({15'h0000, (got >= start && got <= count_q)}, 16'h0001);
			cyc();
		end
		ctl.run = 1'b0;
		$display("test phase clock done");
		// synchronised external clock: counts awake, holds in sleep, one held step on waking
		ctl.src_ext = 1'b1;
		start = 16'h1000 + 16'($urandom_range(255));
		load(start);
		ctl.run = 1'b1;
		run_xtal($urandom_range(1500, 500));
		exp = start + 16'(edges);
		chk(count_q, exp);
		chk({15'h0000, tb_ok}, 16'h0001);
		sleep = 1'b1;
		run_xtal($urandom_range(1500, 500));
		chk(count_q, exp);
		sleep = 1'b0;
		cyc(8);
		chk(count_q, exp + 16'(edges != 0));
		ctl.run = 1'b0;
		$display("test synchronised clock done");
		give_verdict();
	end
endmodule : testbench
